// ===== bls_pkg.sv
/*
  Package for the broadcast limiter and port statistics block: register map,
  field layout, reset values, timing counts and operating modes.
  Assumes a 25 MHz core clock.
*/
package bls_pkg;
  localparam int          BLS_PORTS       = 8;
  localparam int          BLS_CW          = 32;
  localparam int          BLS_AW          = 8;
  localparam int          BLS_CLK_HZ      = 25000000;
  localparam int          BLS_WIN_S       = 1;
  localparam int          BLS_WIN_CYC     = BLS_CLK_HZ * BLS_WIN_S;
  localparam logic [31:0] BLS_THR_RESET   = 32'hffffffff;
  localparam logic [31:0] BLS_ZERO        = 32'h00000000;
  // Register index: bits [7:5] select the table, bits [2:0] the port
  localparam logic [2:0]  BLS_T_THR       = 3'h0;
  localparam logic [2:0]  BLS_T_TOTAL     = 3'h1;
  localparam logic [2:0]  BLS_T_PEAK      = 3'h2;
  localparam logic [2:0]  BLS_T_SINCE     = 3'h3;
  localparam logic [2:0]  BLS_T_RX        = 3'h4;
  localparam logic [2:0]  BLS_T_TX        = 3'h5;
  localparam logic [2:0]  BLS_T_FLT       = 3'h6;
  localparam logic [2:0]  BLS_T_CTRL      = 3'h7;
  localparam logic [2:0]  BLS_CTRL_MODE   = 3'h0;
  localparam logic [2:0]  BLS_CTRL_PEAKCLR = 3'h1;
  localparam logic [2:0]  BLS_CTRL_CNTCLR = 3'h2;
  localparam logic [2:0]  BLS_CTRL_FWD    = 3'h3;
  localparam int          BLS_MODE_W      = 2;
  localparam logic [1:0]  BLS_MODE_RESET  = 2'h0;

  typedef enum logic [1:0] {
    BLS_MODE_8021D  = 2'h0,
    BLS_MODE_8021Q  = 2'h1,
    BLS_MODE_SECURE = 2'h3
  } bls_mode_e;
endpackage : bls_pkg

// ===== bls_limiter.sv
/*
  Broadcast storm limiter and per-port frame statistics for eight ports.
  Assumes frame event pulses from logic on core_clk, one cycle per frame,
  and a management master on the plain register port.
*/
// The register addresses and the strobed register port were decided locally.
// Function
// - Broadcast frames over the port threshold in the current second are dropped in 802.1D mode.
// - Each port holds its own threshold of broadcast frames forwarded per second.
// - Each port keeps a readable running total of received broadcast frames.
// - Each port records the highest broadcast count seen in any one-second window.
// - Each port keeps a readable time in seconds since its peak was reached.
// - A peak clear zeroes the peak and restarts the time since peak.
// - The peak clear control is inactive after reset.
// - Suppression is off in secure VLAN mode and in 802.1Q mode.
// - Each port counts received frames from zero after reset.
// - Each port counts transmitted frames from zero after reset.
// - Switch statistics run in every mode value except secure VLAN mode.
// - Each port counts filtered and forwarded frames from zero after reset.
// - A clear-counters command zeroes all switch statistics counters.
`timescale 1ns/1ns
module bls_limiter
  import bls_pkg::*;
#(
  parameter int WIN_CYC = BLS_WIN_CYC
)(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [BLS_AW-1:0]    reg_addr,
  input  wire logic [BLS_CW-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [BLS_CW-1:0]    reg_rdata,
  input  wire logic [BLS_PORTS-1:0] bc_rx,
  input  wire logic [BLS_PORTS-1:0] rx_frame,
  input  wire logic [BLS_PORTS-1:0] tx_frame,
  input  wire logic [BLS_PORTS-1:0] flt_frame,
  input  wire logic [BLS_PORTS-1:0] fwd_frame,
  output logic      [BLS_PORTS-1:0] bc_drop,
  output logic      [BLS_PORTS-1:0] bc_pass
);
  logic [31:0]         win_cnt;
  logic                tick;
  logic [BLS_MODE_W-1:0] mode;
  logic                supp_on;
  logic                stats_on;
  logic [BLS_PORTS-1:0] peak_clr;
  logic                cnt_clr;
  logic [2:0]          tbl;
  logic [2:0]          prt;
  logic [BLS_CW-1:0]   thr   [BLS_PORTS];
  logic [BLS_CW-1:0]   total [BLS_PORTS];
  logic [BLS_CW-1:0]   peak  [BLS_PORTS];
  logic [BLS_CW-1:0]   since [BLS_PORTS];
  logic [BLS_CW-1:0]   wcnt  [BLS_PORTS];
  logic [BLS_CW-1:0]   rxc   [BLS_PORTS];
  logic [BLS_CW-1:0]   txc   [BLS_PORTS];
  logic [BLS_CW-1:0]   fltc  [BLS_PORTS];
  logic [BLS_CW-1:0]   fwdc  [BLS_PORTS];

  assign tbl      = reg_addr[7:5];
  assign prt      = reg_addr[2:0];
  assign supp_on  = (mode == BLS_MODE_8021D);
  assign stats_on = (mode != BLS_MODE_SECURE);

  function automatic logic [BLS_CW-1:0] sat_inc(input logic [BLS_CW-1:0] v);
    sat_inc = (v == BLS_THR_RESET) ? v : v + 32'h00000001;
  endfunction : sat_inc

  // One-second window timer
  always_ff @(posedge core_clk)
  begin
    if (reset || tick)
      win_cnt <= BLS_ZERO;
    else
      win_cnt <= win_cnt + 32'h00000001;
  end
  assign tick = (win_cnt == 32'(WIN_CYC - 1));

  // Control writes; clear strobes self-clear
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mode     <= BLS_MODE_RESET;
      peak_clr <= '0;
      cnt_clr  <= 1'b0;
    end
    else
    begin
      peak_clr <= '0;
      cnt_clr  <= 1'b0;
      if (reg_wr && tbl == BLS_T_CTRL)
      begin
        unique case (prt)
          BLS_CTRL_MODE:    mode     <= reg_wdata[BLS_MODE_W-1:0];
          BLS_CTRL_PEAKCLR: peak_clr <= reg_wdata[BLS_PORTS-1:0];
          BLS_CTRL_CNTCLR:  cnt_clr  <= reg_wdata[0];
          default:          ;
        endcase
      end
    end
  end

  peak_clr_idle_a : assert property (@(posedge core_clk) disable iff (reset)
    peak_clr != '0 |-> $past(reg_wr && tbl == BLS_T_CTRL && prt == BLS_CTRL_PEAKCLR))
    else $error("Peak clear without request");
  mode_write_a : assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && tbl == BLS_T_CTRL && prt == BLS_CTRL_MODE
    |=> mode == $past(reg_wdata[BLS_MODE_W-1:0])) else $error("Mode write lost");

  generate
    for (genvar p = 0; p < BLS_PORTS; p++)
    begin : g_port
      logic over;
      assign over = supp_on && (wcnt[p] >= thr[p]);

      always_ff @(posedge core_clk)
      begin
        if (reset)
          thr[p] <= BLS_THR_RESET;
        else if (reg_wr && tbl == BLS_T_THR && prt == 3'(p))
          thr[p] <= reg_wdata;
      end

      thr_write_a : assert property (@(posedge core_clk) disable iff (reset)
        reg_wr && tbl == BLS_T_THR && prt == 3'(p) |=> thr[p] == $past(reg_wdata))
        else $error("Threshold write lost");

      // Drop or pass decision per broadcast frame
      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          bc_drop[p] <= 1'b0;
          bc_pass[p] <= 1'b0;
        end
        else
        begin
          bc_drop[p] <= bc_rx[p] && over;
          bc_pass[p] <= bc_rx[p] && !over;
        end
      end

      drop_decide_a : assert property (@(posedge core_clk) disable iff (reset)
        bc_rx[p] && supp_on && wcnt[p] >= thr[p] |=> bc_drop[p] && !bc_pass[p])
        else $error("Frame over threshold not dropped");
      pass_decide_a : assert property (@(posedge core_clk) disable iff (reset)
        bc_rx[p] && !(supp_on && wcnt[p] >= thr[p]) |=> bc_pass[p] && !bc_drop[p])
        else $error("Frame under threshold not passed");
      no_frame_idle_a : assert property (@(posedge core_clk) disable iff (reset)
        !bc_rx[p] |=> !bc_drop[p] && !bc_pass[p]) else $error("Result without a frame");
      supp_off_a : assert property (@(posedge core_clk) disable iff (reset)
        mode != BLS_MODE_8021D |=> !bc_drop[p])
        else $error("Drop while suppression unavailable");

      always_ff @(posedge core_clk)
      begin
        if (reset)
          total[p] <= BLS_ZERO;
        else if (bc_rx[p])
          total[p] <= sat_inc(total[p]);
      end

      total_sat_a : assert property (@(posedge core_clk) disable iff (reset)
        total[p] == BLS_THR_RESET |=> total[p] == BLS_THR_RESET)
        else $error("Total wrapped");
      total_hold_a : assert property (@(posedge core_clk) disable iff (reset)
        !bc_rx[p] |=> $stable(total[p]))
        else $error("Total moved without a frame");

      // Window count, peak and time since peak
      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          wcnt[p]  <= BLS_ZERO;
          peak[p]  <= BLS_ZERO;
          since[p] <= BLS_ZERO;
        end
        else
        begin
          if (tick)
            wcnt[p] <= {{(BLS_CW-1){1'b0}}, bc_rx[p]};
          else if (bc_rx[p])
            wcnt[p] <= sat_inc(wcnt[p]);
          if (peak_clr[p])
          begin
            peak[p]  <= BLS_ZERO;
            since[p] <= BLS_ZERO;
          end
          else if (tick && wcnt[p] > peak[p])
          begin
            peak[p]  <= wcnt[p];
            since[p] <= BLS_ZERO;
          end
          else if (tick)
            since[p] <= sat_inc(since[p]);
        end
      end

      since_step_a : assert property (@(posedge core_clk) disable iff (reset)
        tick && !peak_clr[p] && wcnt[p] <= peak[p] && since[p] != BLS_THR_RESET
        |=> since[p] == $past(since[p]) + 32'h00000001)
        else $error("Time since peak not advanced");
      since_hold_a : assert property (@(posedge core_clk) disable iff (reset)
        !tick && !peak_clr[p] |=> $stable(since[p]) && $stable(peak[p]))
        else $error("Peak changed between ticks");
      peak_floor_a : assert property (@(posedge core_clk) disable iff (reset)
        tick && !peak_clr[p] |=> peak[p] >= $past(wcnt[p]))
        else $error("Peak below a window count");
      window_count_a : assert property (@(posedge core_clk) disable iff (reset)
        !tick && bc_rx[p] && wcnt[p] != BLS_THR_RESET
        |=> wcnt[p] == $past(wcnt[p]) + 32'h00000001)
        else $error("Window count missed a frame");

      // Switch statistics
      always_ff @(posedge core_clk)
      begin
        if (reset || cnt_clr)
        begin
          rxc[p]  <= BLS_ZERO;
          txc[p]  <= BLS_ZERO;
          fltc[p] <= BLS_ZERO;
          fwdc[p] <= BLS_ZERO;
        end
        else if (stats_on)
        begin
          if (rx_frame[p])
            rxc[p] <= sat_inc(rxc[p]);
          if (tx_frame[p])
            txc[p] <= sat_inc(txc[p]);
          if (flt_frame[p])
            fltc[p] <= sat_inc(fltc[p]);
          if (fwd_frame[p])
            fwdc[p] <= sat_inc(fwdc[p]);
        end
      end

      rx_count_a : assert property (@(posedge core_clk) disable iff (reset)
        stats_on && !cnt_clr && rx_frame[p] && rxc[p] != BLS_THR_RESET
        |=> rxc[p] == $past(rxc[p]) + 32'h00000001) else $error("Receive frame missed");
      tx_count_a : assert property (@(posedge core_clk) disable iff (reset)
        stats_on && !cnt_clr && tx_frame[p] && txc[p] != BLS_THR_RESET
        |=> txc[p] == $past(txc[p]) + 32'h00000001) else $error("Transmit frame missed");
      flt_count_a : assert property (@(posedge core_clk) disable iff (reset)
        stats_on && !cnt_clr && flt_frame[p] && fltc[p] != BLS_THR_RESET
        |=> fltc[p] == $past(fltc[p]) + 32'h00000001) else $error("Filtered frame missed");
      fwd_count_a : assert property (@(posedge core_clk) disable iff (reset)
        stats_on && !cnt_clr && fwd_frame[p] && fwdc[p] != BLS_THR_RESET
        |=> fwdc[p] == $past(fwdc[p]) + 32'h00000001) else $error("Forwarded frame missed");
    end
  endgenerate

  // Read port, data valid one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (reset || !reg_rd)
      reg_rdata <= BLS_ZERO;
    else
    begin
      unique case (tbl)
        BLS_T_THR:   reg_rdata <= thr[prt];
        BLS_T_TOTAL: reg_rdata <= total[prt];
        BLS_T_PEAK:  reg_rdata <= peak[prt];
        BLS_T_SINCE: reg_rdata <= since[prt];
        BLS_T_RX:    reg_rdata <= rxc[prt];
        BLS_T_TX:    reg_rdata <= txc[prt];
        BLS_T_FLT:   reg_rdata <= fltc[prt];
        BLS_T_CTRL:  reg_rdata <= (prt == BLS_CTRL_MODE) ? 32'(mode) :
                                  (prt == BLS_CTRL_PEAKCLR) ? 32'(peak_clr) : BLS_ZERO;
      endcase
      if (tbl == BLS_T_FLT && reg_addr[3])
        reg_rdata <= fwdc[prt];
    end
  end

  rdata_idle_a : assert property (@(posedge core_clk) disable iff (reset)
    !reg_rd |=> reg_rdata == BLS_ZERO) else $error("Read data outside read cycle");

  // Assertions
  drop_needs_over_a : assert property (@(posedge core_clk) disable iff (reset)
    bc_drop != '0 |-> $past(supp_on)) else $error("Drop outside suppression mode");
  no_drop_off_a : assert property (@(posedge core_clk) disable iff (reset)
    !supp_on && bc_rx[0] |=> !bc_drop[0]) else $error("Drop while suppression off");
  drop_pass_excl_a : assert property (@(posedge core_clk) disable iff (reset)
    (bc_drop & bc_pass) == '0) else $error("Frame both dropped and passed");
  total_counts_a : assert property (@(posedge core_clk) disable iff (reset)
    bc_rx[0] && total[0] != BLS_THR_RESET |=> total[0] == $past(total[0]) + 32'h1)
    else $error("Total missed a broadcast");
  peak_update_a : assert property (@(posedge core_clk) disable iff (reset)
    tick && !peak_clr[0] && wcnt[0] > peak[0] |=> peak[0] == $past(wcnt[0]))
    else $error("Peak not updated");
  peak_clear_a : assert property (@(posedge core_clk) disable iff (reset)
    peak_clr[0] |=> peak[0] == BLS_ZERO && since[0] == BLS_ZERO)
    else $error("Peak clear incomplete");
  window_restart_a : assert property (@(posedge core_clk) disable iff (reset)
    tick |=> wcnt[0] == {31'h0, $past(bc_rx[0])})
    else $error("Window count not restarted");
  count_clear_a : assert property (@(posedge core_clk) disable iff (reset)
    cnt_clr |=> rxc[0] == BLS_ZERO && txc[0] == BLS_ZERO && fltc[0] == BLS_ZERO &&
    fwdc[0] == BLS_ZERO) else $error("Counters not cleared");
  stats_hold_a : assert property (@(posedge core_clk) disable iff (reset)
    !stats_on && !cnt_clr |=> rxc[0] == $past(rxc[0])) else $error("Stats in secure mode");
  rx_sat_a : assert property (@(posedge core_clk) disable iff (reset)
    rxc[0] == BLS_THR_RESET && !cnt_clr |=> rxc[0] == BLS_THR_RESET)
    else $error("Counter wrapped");
endmodule : bls_limiter

// ===== bls_port_src.sv
/*
  Frame event source standing in for the switch port receive and transmit paths.
  Assumes core_clk from the testbench; idle lines stay low between events.
*/
`timescale 1ns/1ns
module bls_port_src
  import bls_pkg::*;
(
  input  wire logic                 core_clk,
  output logic      [BLS_PORTS-1:0] bc_rx,
  output logic      [BLS_PORTS-1:0] rx_frame,
  output logic      [BLS_PORTS-1:0] tx_frame,
  output logic      [BLS_PORTS-1:0] flt_frame,
  output logic      [BLS_PORTS-1:0] fwd_frame
);
  logic [BLS_PORTS-1:0] zero_v = '0;
  initial
  begin
    {bc_rx, rx_frame, tx_frame, flt_frame, fwd_frame} = '0;
  end

  // Pulse one event kind on one port for n back-to-back cycles
  task automatic send(input logic [2:0] kind, input int port, input int n);
    logic [BLS_PORTS-1:0] v;
    v = zero_v;
    v[port] = 1'b1;
    @(posedge core_clk);
    case (kind)
      3'h0: bc_rx <= v;
      3'h1: rx_frame <= v;
      3'h2: tx_frame <= v;
      3'h3: flt_frame <= v;
      default: fwd_frame <= v;
    endcase
    repeat (n) @(posedge core_clk);
    {bc_rx, rx_frame, tx_frame, flt_frame, fwd_frame} <= '0;
  endtask : send
endmodule : bls_port_src

// ===== bls_limiter_tb.sv
/*
  Self-checking testbench for the broadcast limiter and port statistics.
  Assumes a one-second window shortened through WIN_CYC.
*/
`timescale 1ns/1ns
module bls_limiter_tb;
  import bls_pkg::*;
  localparam int W = 2000;
  logic                 core_clk, reset, reg_wr, reg_rd;
  logic [BLS_AW-1:0]    reg_addr;
  logic [BLS_CW-1:0]    reg_wdata, reg_rdata;
  logic [BLS_PORTS-1:0] bc_rx, rx_frame, tx_frame, flt_frame, fwd_frame, bc_drop, bc_pass;
  logic [31:0]          npass, ndrop;
  int                   failures, comparisons;

  bls_limiter #(.WIN_CYC(W)) dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bc_rx(bc_rx), .rx_frame(rx_frame), .tx_frame(tx_frame), .flt_frame(flt_frame),
    .fwd_frame(fwd_frame), .bc_drop(bc_drop), .bc_pass(bc_pass));
  bls_port_src src_u (.core_clk(core_clk), .bc_rx(bc_rx), .rx_frame(rx_frame),
    .tx_frame(tx_frame), .flt_frame(flt_frame), .fwd_frame(fwd_frame));

  // Pass and drop tallies for port 3
  always @(posedge core_clk)
  begin
    npass <= reset ? 32'h0 : npass + {31'h0, bc_pass[3]};
    ndrop <= reset ? 32'h0 : ndrop + {31'h0, bc_drop[3]};
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(nm, reg_rdata, e);
  endtask : rd_chk

  task automatic burst(input logic [31:0] ep, input logic [31:0] ed);
    logic [31:0] p0;
    logic [31:0] d0;
    p0 = npass;
    d0 = ndrop;
    src_u.send(3'h0, 3, 12);
    repeat (2) @(posedge core_clk);
    check("passed", npass - p0, ep);
    check("dropped", ndrop - d0, ed);
  endtask : burst

  task automatic t_reset_vals;
    rd_chk("threshold", 8'h00, BLS_THR_RESET);
    rd_chk("mode", 8'he0, 32'h0);
    rd_chk("peak clear", 8'he1, 32'h0);
    rd_chk("unused ctrl", 8'he7, 32'h0);
    rd_chk("rx", 8'h87, 32'h0);
    rd_chk("tx", 8'ha7, 32'h0);
    rd_chk("filtered", 8'hc7, 32'h0);
    rd_chk("forwarded", 8'hcf, 32'h0);
  endtask : t_reset_vals

  task automatic t_limit;
    wr(8'h03, 32'h0000000a);
    rd_chk("threshold", 8'h03, 32'h0000000a);
    burst(32'h0000000a, 32'h00000002);
    wr(8'h23, 32'h00000005);
    rd_chk("total", 8'h23, 32'h0000000c);
  endtask : t_limit

  task automatic t_peak;
    repeat (W) @(posedge core_clk);
    rd_chk("peak", 8'h43, 32'h0000000c);
    rd_chk("since", 8'h63, 32'h0);
    repeat (W) @(posedge core_clk);
    rd_chk("since", 8'h63, 32'h00000001);
    rd_chk("peak kept", 8'h43, 32'h0000000c);
    wr(8'he1, 32'h00000008);
    rd_chk("peak", 8'h43, 32'h0);
    rd_chk("since", 8'h63, 32'h0);
  endtask : t_peak

  task automatic t_modes;
    wr(8'he0, 32'h00000001);
    rd_chk("mode", 8'he0, 32'h00000001);
    burst(32'h0000000c, 32'h0);
    src_u.send(3'h1, 5, 3);
    rd_chk("rx", 8'h85, 32'h00000003);
    wr(8'he0, 32'h00000003);
    burst(32'h0000000c, 32'h0);
    src_u.send(3'h1, 5, 3);
    rd_chk("rx secure", 8'h85, 32'h00000003);
    wr(8'he0, 32'h0);
  endtask : t_modes

  task automatic t_stats;
    logic [7:0] a [4];
    a = '{8'h85, 8'ha5, 8'hc5, 8'hcd};
    for (int k = 0; k < 4; k++)
      src_u.send(k[2:0] + 3'h1, 5, k + 2);
    rd_chk("rx", a[0], 32'h00000005);
    rd_chk("tx", a[1], 32'h00000003);
    rd_chk("filtered", a[2], 32'h00000004);
    rd_chk("forwarded", a[3], 32'h00000005);
    wr(8'he2, 32'h00000001);
    for (int k = 0; k < 4; k++)
      rd_chk("cleared", a[k], 32'h0);
    rd_chk("total", 8'h23, 32'h00000024);
  endtask : t_stats

  task automatic t_rerun;
    src_u.send(3'h1, 2, 4);
    rd_chk("rx", 8'h82, 32'h00000004);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk("rx after reset", 8'h82, 32'h0);
    rd_chk("total after reset", 8'h23, 32'h0);
    rd_chk("threshold after reset", 8'h03, BLS_THR_RESET);
  endtask : t_rerun

  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (4 * W) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    reset = 1'b1;
    failures = 0;
    comparisons = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_vals();
    t_limit();
    t_peak();
    t_modes();
    t_stats();
    t_rerun();
    report_and_stop();
  end
endmodule : bls_limiter_tb
